// ===== src/icp_top.sv
/*
 Image capture port: takes bytes pushed by an external image processor and
 issues display-memory writes with a frame/line address sequencer, plus the
 external register decode output.
 Assumes the strobe, mask, syncs and data arrive asynchronously to core_clk,
 that data and mask are stable around the strobe's rising edge, and that the
 memory write port accepts a write when mem_wr_ack is high.
*/
`timescale 1ns/10ps
`default_nettype none
module icp_top #(
   parameter int LINE_PITCH = icp_pkg::LINE_PITCH_DEF
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [7:0] image_port_cfg_index,
   input wire logic [15:0] port_data_bus,
   input wire logic upper_byte_mask,
   input wire logic byte_accept_mask,
   input wire logic ext_write_strobe_n,
   input wire logic frame_sync_in,
   input wire logic line_sync_in,
   input wire logic odd_field_in,
   input wire logic host_ext_reg_hit,
   input wire logic mem_wr_ack,
   output logic port_ready_out,
   output logic port_ready_oe_n,
   output logic ext_reg_cmd_n,
   output logic ext_reg_cmd_oe_n,
   output logic port_sel,
   output logic mem_wr_en,
   output logic [icp_pkg::ADDR_W-1:0] mem_wr_addr,
   output logic [icp_pkg::DATA_W-1:0] mem_wr_data,
   output logic odd_field
);
   logic [3:0] sync_lvl;
   logic [3:0] sync_rise;
   logic [7:0] data_meta_q;
   logic [7:0] data_stab_q;
   logic mask_meta_q;
   logic mask_stab_q;
   logic sel;
   logic strobe_rise;
   logic frame_rise;
   logic line_rise;
   logic [icp_pkg::ADDR_W-1:0] line_next;
   icp_pkg::icp_state_t state_q, state_d;
   logic [icp_pkg::ADDR_W-1:0] addr_q, addr_d;
   logic [icp_pkg::ADDR_W-1:0] line_base_q, line_base_d;
   logic [icp_pkg::DATA_W-1:0] wdata_q, wdata_d;
   logic wen_q, wen_d;
   logic rdy_q, rdy_d;
   logic cmd_n_q, cmd_n_d;
   logic sel_q, sel_d;
   logic odd_q, odd_d;

   // ****************************************
   // Pin synchronisation
   // ****************************************
   // Strobe is active low, so its release is the rising edge that captures a byte;
   // its stages reset high to match the idle pin and avoid a false capture edge
   icp_sync #(
      .WIDTH(4),
      .RST_VAL(4'h1)
   ) u_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .async_in({odd_field_in, line_sync_in, frame_sync_in, ext_write_strobe_n}),
      .level_out(sync_lvl),
      .rise_out(sync_rise)
   );

   // Data and mask sampled on same depth as the strobe; bus holds them past
   // the edge, so the two-flop copy is settled when the edge pulse appears
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         data_meta_q <= 8'h00;
         data_stab_q <= 8'h00;
         mask_meta_q <= 1'b0;
         mask_stab_q <= 1'b0;
      end else begin
         data_meta_q <= port_data_bus[7:0];
         data_stab_q <= data_meta_q;
         mask_meta_q <= byte_accept_mask;
         mask_stab_q <= mask_meta_q;
      end
   end

   // Edges gated by the selection bit
   assign sel = image_port_cfg_index[icp_pkg::SEL_BIT];
   assign strobe_rise = sel_q & sync_rise[0];
   assign frame_rise = sel_q & sync_rise[1];
   assign line_rise = sel_q & sync_rise[2];

   // Next line start, shared by base and address on a line edge
   assign line_next = line_base_q + icp_pkg::ADDR_W'(LINE_PITCH);

   // ****************************************
   // Helpers
   // ****************************************
   // Sequencer step, shared by skipped and written bytes; wraps at the top
   function automatic logic [icp_pkg::ADDR_W-1:0] step_addr(
      input logic [icp_pkg::ADDR_W-1:0] a
   );
      return a + icp_pkg::ADDR_W'(1);
   endfunction

   // ****************************************
   // Sequencer and write control
   // ****************************************
   // Ready drops while a write is pending, so bytes never overrun memory
   always_comb begin
      state_d = state_q;
      addr_d = addr_q;
      line_base_d = line_base_q;
      wdata_d = wdata_q;
      wen_d = wen_q;
      rdy_d = rdy_q;
      sel_d = sel;
      odd_d = sel_q & sync_lvl[3];
      cmd_n_d = ~(sel & host_ext_reg_hit);
      if (frame_rise) begin
         addr_d = icp_pkg::ADDR_RST;
         line_base_d = icp_pkg::ADDR_RST;
      end else if (line_rise) begin
         line_base_d = line_next;
         addr_d = line_next;
      end
      unique case (state_q)
         icp_pkg::ICP_IDLE: begin
            rdy_d = sel_q;
            if (strobe_rise) begin
               if (mask_stab_q) begin
                  wdata_d = data_stab_q;
                  wen_d = 1'b1;
                  rdy_d = 1'b0;
                  state_d = icp_pkg::ICP_WRITE;
               end else begin
                  addr_d = step_addr(addr_q);
               end
            end
         end
         icp_pkg::ICP_WRITE: begin
            // Ready stays low so strobes cannot overrun a pending write
            rdy_d = 1'b0;
            if (mem_wr_ack) begin
               wen_d = 1'b0;
               addr_d = step_addr(addr_q);
               state_d = icp_pkg::ICP_HOLD;
            end
         end
         icp_pkg::ICP_HOLD: begin
            // One spare cycle lets the address settle before the next byte
            rdy_d = sel_q;
            state_d = icp_pkg::ICP_IDLE;
         end
      endcase
      if (!sel_q) begin
         wen_d = 1'b0;
         state_d = icp_pkg::ICP_IDLE;
      end
   end

   // Register stage only
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_q <= icp_pkg::ICP_IDLE;
         addr_q <= icp_pkg::ADDR_RST;
         line_base_q <= icp_pkg::ADDR_RST;
         wdata_q <= 8'h00;
         wen_q <= 1'b0;
         rdy_q <= 1'b0;
         cmd_n_q <= 1'b1;
         sel_q <= 1'b0;
         odd_q <= 1'b0;
      end else begin
         state_q <= state_d;
         addr_q <= addr_d;
         line_base_q <= line_base_d;
         wdata_q <= wdata_d;
         wen_q <= wen_d;
         rdy_q <= rdy_d;
         cmd_n_q <= cmd_n_d;
         sel_q <= sel_d;
         odd_q <= odd_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Enables low drive the shared pins only in image port mode
   assign port_ready_out = rdy_q;
   assign port_ready_oe_n = ~sel_q;
   assign ext_reg_cmd_n = cmd_n_q;
   assign ext_reg_cmd_oe_n = ~sel_q;
   assign port_sel = sel_q;

   // Memory write port; data stands unchanged while the write is pending, address steps after an ack or skipped byte, else jumps on a frame or line edge
   assign mem_wr_en = wen_q;
   assign mem_wr_addr = addr_q;
   assign mem_wr_data = wdata_q;
   assign odd_field = odd_q;
endmodule
`default_nettype wire

// ===== src/icp_pkg.sv
/*
 Shared constants for the image capture port: configuration bit position,
 address widths, reset values and line geometry defaults.
 Assumes nothing of its surroundings beyond a single core clock.
*/
package icp_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 8;
   localparam int LINE_PITCH_DEF = 1024;
   localparam int SEL_BIT = 0;
   localparam logic [19:0] ADDR_RST = 20'h0_0000;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam int SYNC_STAGES = 2;
   typedef enum logic [1:0] {
      ICP_IDLE,
      ICP_WRITE,
      ICP_HOLD
   } icp_state_t;
endpackage

// ===== src/icp_sync.sv
/*
 Two-flop synchroniser with a rising-edge pulse, one per bit in a generate loop.
 Assumes asynchronous inputs and one core clock with a synchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none
module icp_sync #(
   parameter int WIDTH = 4,
   // Reset level per bit, set to each pin's idle level so no false edge follows reset
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] level_out,
   output logic [WIDTH-1:0] rise_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] stab_q;
   logic [WIDTH-1:0] prev_q;

   // ****************************************
   // Synchroniser stages
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         // First flop is read only by the second
         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               meta_q[gi] <= RST_VAL[gi];
               stab_q[gi] <= RST_VAL[gi];
               prev_q[gi] <= RST_VAL[gi];
            end else begin
               meta_q[gi] <= async_in[gi];
               stab_q[gi] <= meta_q[gi];
               prev_q[gi] <= stab_q[gi];
            end
         end
      end
   endgenerate

   // Edge pulse from stable stages
   assign level_out = stab_q;
   assign rise_out = stab_q & ~prev_q;
endmodule
`default_nettype wire

// ===== dv/icp_chk.sv
/* Port checker for icp_top.
 Sees only the top ports; bound in below. */
`timescale 1ns/10ps
`default_nettype none
module icp_chk (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [7:0] image_port_cfg_index,
   input wire logic host_ext_reg_hit,
   input wire logic mem_wr_ack,
   input wire logic port_ready_out,
   input wire logic port_ready_oe_n,
   input wire logic ext_reg_cmd_n,
   input wire logic ext_reg_cmd_oe_n,
   input wire logic port_sel,
   input wire logic mem_wr_en,
   input wire logic [icp_pkg::ADDR_W-1:0] mem_wr_addr
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // Select and decode lag their causes by one edge
   a_sel_cfg: assert property (port_sel == $past(image_port_cfg_index[0]))
      else $error("select lag wrong");
   a_oe_sel: assert property (port_ready_oe_n == !port_sel) else $error("ready oe");
   a_cmd_oe: assert property (ext_reg_cmd_oe_n == !port_sel) else $error("cmd oe");
   a_cmd_dec: assert property (port_sel && $past(port_sel) |->
      ext_reg_cmd_n == !$past(host_ext_reg_hit)) else $error("cmd decode");
   a_off_quiet: assert property (!port_sel && !$past(port_sel) |->
      !port_ready_out && !mem_wr_en) else $error("active while off");
   // A write stands until acked, then steps and reopens
   a_wr_hold: assert property (mem_wr_en && !mem_wr_ack |=>
      mem_wr_en && $stable(mem_wr_addr)) else $error("write dropped");
   a_wr_step: assert property (mem_wr_en && mem_wr_ack |=>
      !mem_wr_en && mem_wr_addr == $past(mem_wr_addr) + icp_pkg::ADDR_W'(1))
      else $error("no step");
   a_ready_back: assert property (mem_wr_en && mem_wr_ack |=>
      !port_ready_out ##1 port_ready_out) else $error("ready timing");
   a_busy_wr: assert property ($rose(mem_wr_en) |-> !port_ready_out) else $error("busy");
   c_stall: cover property (mem_wr_en && !mem_wr_ack ##1 mem_wr_ack);
   c_cmd: cover property ($fell(ext_reg_cmd_n));
   c_rdy: cover property ($rose(port_ready_out));
endmodule
bind icp_top icp_chk u_chk (.*);
`default_nettype wire

// ===== dv/icp_ext_model.sv
/* External image source: pushes one byte per call.
 Paces itself on its own synchronised copy of ready. */
`timescale 1ns/10ps
`default_nettype none
module icp_ext_model (
   input wire logic core_clk,
   input wire logic port_ready_out,
   output var logic [15:0] port_data_bus,
   output var logic upper_byte_mask,
   output var logic byte_accept_mask,
   output var logic ext_write_strobe_n
);
   logic [1:0] rdy_q = 2'b00;
   // Ready is foreign here, so two flops first
   always @(posedge core_clk) rdy_q <= {rdy_q[0], port_ready_out};
   // Strobe idles high
   initial {port_data_bus, upper_byte_mask, byte_accept_mask, ext_write_strobe_n} = 19'h0_0001;
   // Data turns over once hold is done, so stale bytes never pass
   task automatic send(input logic [7:0] b, input logic m, output logic ok);
      repeat (4) @(negedge core_clk);
      // Stale byte and mask at the falling edge; only the rising edge may capture
      ext_write_strobe_n = 1'b0;
      repeat (2) @(negedge core_clk);
      {port_data_bus, upper_byte_mask, byte_accept_mask} = {~b, b, ~m, m};
      repeat (6) @(negedge core_clk);
      ext_write_strobe_n = 1'b1;
      repeat (8) @(negedge core_clk);
      port_data_bus = ~port_data_bus;
      for (int i = 0; i < 60 && !rdy_q[1]; i++) @(negedge core_clk);
      ok = rdy_q[1];
   endtask
endmodule
`default_nettype wire

// ===== dv/tb.sv
/* Bench for icp_top: source model on the port, memory acks here.
 Assumes the checker binds itself in. */
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic core_clk = 1'b0, sys_rst = 1'b1, host_ext_reg_hit = 1'b0, mem_wr_ack = 1'b0, ok;
   logic odd_field_in = 1'b0, frame_sync_in = 1'b0, line_sync_in = 1'b0, upper_byte_mask;
   logic byte_accept_mask, ext_write_strobe_n, port_ready_out, port_ready_oe_n, ext_reg_cmd_n;
   logic ext_reg_cmd_oe_n, port_sel, mem_wr_en, odd_field;
   logic [7:0] image_port_cfg_index = 8'h00, mem_wr_data, d_q;
   logic [15:0] port_data_bus;
   logic [19:0] mem_wr_addr, a_q;
   int n_mismatch = 0, check_count = 0, nw = 0, dly = 0, cnt = 0;
   // Clock, partner and a short line pitch
   always #5 core_clk = ~core_clk;
   icp_ext_model ext (.*);
   icp_top #(.LINE_PITCH(16)) dut (.*);
   // Memory acks after dly stall cycles and logs each write
   always @(negedge core_clk) begin
      cnt = mem_wr_en ? cnt + 1 : 0;
      mem_wr_ack <= mem_wr_en && cnt > dly;
   end
   always @(posedge core_clk)
      if (mem_wr_en && mem_wr_ack) {nw, a_q, d_q} <= {nw + 1, mem_wr_addr, mem_wr_data};
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
         n_mismatch++;
      end
   endtask
   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic t_sel();
      host_ext_reg_hit = 1'b1;
      ext.send(8'h3C, 1'b1, ok);
      chk({nw[3:0], ok, ext_reg_cmd_n, port_ready_out}, 7'h02);
      image_port_cfg_index = 8'h01;
      odd_field_in = 1'b1;
      repeat (4) @(negedge core_clk);
      chk({ext_reg_cmd_n, port_ready_out, odd_field}, 3'b011);
      {host_ext_reg_hit, odd_field_in} = 2'b00;
      repeat (4) @(negedge core_clk);
      chk({ext_reg_cmd_n, odd_field}, 2'b10);
      $display("t_sel done");
   endtask
   task automatic t_stream();
      logic [7:0] b[5] = '{8'hA5, 8'h11, 8'h5A, 8'hB7, 8'hC3};
      int ea[5] = '{0, 0, 2, 16, 0};
      for (int i = 0; i < 5; i++) begin
         dly = 2 * i;
         {frame_sync_in, line_sync_in} = {i == 4, i == 3};
         repeat (4) @(negedge core_clk);
         {frame_sync_in, line_sync_in} = 2'b00;
         repeat (4) @(negedge core_clk);
         ext.send(b[i], i != 1, ok);
         chk(ok, 1);
         if (ok !== 1'b1) finish_test();
         chk(nw, i + (i == 0));
         chk(a_q, ea[i]);
         chk(d_q, b[i == 1 ? 0 : i]);
      end
      $display("t_stream done");
   endtask
   initial begin
      repeat (6) @(posedge core_clk);
      @(negedge core_clk);
      sys_rst = 1'b0;
      t_sel();
      t_stream();
      finish_test();
   end
endmodule
`default_nettype wire
